// ==== core/uir_defines.svh ====
// constants of the usb interrupt enable, event flag and device address block
// assumes a 200 MHz system clock and 32-bit aligned register words
`ifndef UIR_DEFINES_SVH
`define UIR_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define UIR_OFS_IRQ_ENABLE        12'h000
`define UIR_OFS_IRQ_EVENT_FLAGS   12'h004
`define UIR_OFS_DEVICE_ADDRESS    12'h008

// ==========================================================================
// irq_enable field positions
`define UIR_EN_IN_NAK_BIT         15
`define UIR_EN_WAKE_FUNC_BIT      8
`define UIR_EN_WAKE_BIT           3
`define UIR_EN_FLOAT_BIT          2
`define UIR_EN_USB_BIT            1
`define UIR_EN_BUS_BIT            0
`define UIR_EN_WRITABLE           32'h0000_810F
`define UIR_EN_READ_MASK          32'h0000_010F

// ==========================================================================
// irq_event_flags field positions
`define UIR_EVF_SETUP_BIT         31
`define UIR_EVF_EP_LSB            16
`define UIR_EVF_WAKE_BIT          3
`define UIR_EVF_FLOAT_BIT         2
`define UIR_EVF_USB_BIT           1
`define UIR_EVF_BUS_BIT           0
`define UIR_EVF_TRANS_MASK        32'h803F_0000

// ==========================================================================
// device_address field and reset values
`define UIR_ADDR_WRITABLE         32'h0000_007F
`define UIR_RESET_VALUE           32'h0000_0000

// ==========================================================================
// timing
`define UIR_CLK_HZ                200000000
`define UIR_WAKE_QUIET_MS         20

// ==========================================================================
// axi4-lite responses
`define UIR_RESP_OKAY             2'h0
`define UIR_RESP_SLVERR           2'h2

`endif

// ==== core/uir_irq_addr.sv ====
// usb device interrupt enable, event flag and device address registers
// behind an axi4-lite slave port
// assumes event and read strobes are one-cycle pulses on clk_i, and one
// outstanding write and one outstanding read from the bus master
`timescale 1ns/1ps
`include "uir_defines.svh"

module uir_irq_addr #(
  parameter int          ADDR_W            = 12,
  parameter int unsigned WAKE_QUIET_CYCLES = `UIR_WAKE_QUIET_MS * (`UIR_CLK_HZ / 1000)
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]      s_axil_awaddr_i,
  input  wire logic                   s_axil_awvalid_i,
  output logic                        s_axil_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]            s_axil_wdata_i,
  input  wire logic [3:0]             s_axil_wstrb_i,
  input  wire logic                   s_axil_wvalid_i,
  output logic                        s_axil_wready_o,
  // axi4-lite write response
  output logic [1:0]                  s_axil_bresp_o,
  output logic                        s_axil_bvalid_o,
  input  wire logic                   s_axil_bready_i,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]      s_axil_araddr_i,
  input  wire logic                   s_axil_arvalid_i,
  output logic                        s_axil_arready_o,
  // axi4-lite read data
  output logic [31:0]                 s_axil_rdata_o,
  output logic [1:0]                  s_axil_rresp_o,
  output logic                        s_axil_rvalid_o,
  input  wire logic                   s_axil_rready_i,
  // serial engine side
  input  wire uir_pkg::uir_events_t   events_i,
  input  wire uir_pkg::uir_rd_clr_t   rd_clear_i,
  output logic [6:0]                  device_address_o,
  output logic                        wake_function_enable_o,
  output logic                        in_negative_ack_irq_enable_o,
  // interrupt to the system interrupt controller
  output logic                        irq_o
);

  import uir_pkg::*;

  // word index of each register, byte lane bits dropped
  localparam logic [ADDR_W-3:0] EN_IX   = (ADDR_W-2)'(`UIR_OFS_IRQ_ENABLE >> 2);
  localparam logic [ADDR_W-3:0] EVF_IX  = (ADDR_W-2)'(`UIR_OFS_IRQ_EVENT_FLAGS >> 2);
  localparam logic [ADDR_W-3:0] ADDR_IX = (ADDR_W-2)'(`UIR_OFS_DEVICE_ADDRESS >> 2);

  // ==========================================================================
  // bus slave state
  logic              aw_held;        // write address captured
  logic              next_aw_held;
  logic [ADDR_W-1:0] aw_addr;        // captured write address
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_held;         // write data captured
  logic              next_w_held;
  logic [31:0]       w_data;         // captured write data
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;         // captured byte strobes
  logic [3:0]        next_w_strb;
  logic              bvalid;         // write response pending
  logic              next_bvalid;
  logic [1:0]        bresp;          // write response code
  logic [1:0]        next_bresp;
  logic              rvalid;         // read response pending
  logic              next_rvalid;
  logic [1:0]        rresp;          // read response code
  logic [1:0]        next_rresp;
  logic [31:0]       rdata;          // read data
  logic [31:0]       next_rdata;

  // ==========================================================================
  // register state
  logic [31:0]       irq_enable;          // interrupt enables
  logic [31:0]       next_irq_enable;
  logic [31:0]       device_address;      // device address word
  logic [31:0]       next_device_address;
  logic [31:0]       irq_event_flags;     // sticky event flags
  logic [31:0]       flag_set;            // set vector for the flags
  logic [31:0]       flag_clr;            // clear vector for the flags
  logic              trans_any;           // setup or endpoint flag held
  logic              trans_any_d;         // trans_any one cycle ago
  logic              next_trans_any_d;
  logic              wake_release;        // wakeup quiet time elapsed

  // ==========================================================================
  // bus decode
  logic              do_write;       // both halves of a write are here
  logic              do_read;        // read address taken this cycle
  logic [31:0]       byte_mask;      // wstrb spread to bits
  logic [31:0]       w1c;            // write-one-to-clear bits
  logic              wr_en_sel;      // write hits irq_enable
  logic              wr_evf_sel;     // write hits irq_event_flags
  logic              wr_addr_sel;    // write hits device_address

  // a write is done once both address and data are held
  always_comb begin
    do_write    = aw_held && w_held && !bvalid;
    do_read     = s_axil_arvalid_i && !rvalid;
    byte_mask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_en_sel   = do_write && (aw_addr[ADDR_W-1:2] == EN_IX);
    wr_evf_sel  = do_write && (aw_addr[ADDR_W-1:2] == EVF_IX);
    wr_addr_sel = do_write && (aw_addr[ADDR_W-1:2] == ADDR_IX);
    w1c         = wr_evf_sel ? (w_data & byte_mask) : '0;
  end

  // handshake outputs; each channel is taken once and held
  assign s_axil_awready_o = !aw_held && !bvalid;
  assign s_axil_wready_o  = !w_held && !bvalid;
  assign s_axil_arready_o = !rvalid;

  // ==========================================================================
  // write channel: capture, perform, respond
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    // capture address
    if (s_axil_awvalid_i && s_axil_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axil_awaddr_i;
    end
    // capture data
    if (s_axil_wvalid_i && s_axil_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axil_wdata_i;
      next_w_strb = s_axil_wstrb_i;
    end
    // perform and raise the response
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_en_sel || wr_evf_sel || wr_addr_sel) ? `UIR_RESP_OKAY : `UIR_RESP_SLVERR;
    end else if (bvalid && s_axil_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  // register write channel
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= `UIR_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  assign s_axil_bvalid_o = bvalid;
  assign s_axil_bresp_o  = bresp;

  // ==========================================================================
  // read channel: answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = `UIR_RESP_OKAY;
      unique case (s_axil_araddr_i[ADDR_W-1:2])
        // in nak enable reads back as zero
        EN_IX: begin
          next_rdata = irq_enable & `UIR_EN_READ_MASK;
        end
        EVF_IX: begin
          next_rdata = irq_event_flags;
        end
        ADDR_IX: begin
          next_rdata = device_address;
        end
        // unmapped: zero data with slave error
        default: begin
          next_rdata = '0;
          next_rresp = `UIR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axil_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // register read channel
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid <= 1'b0;
      rresp  <= `UIR_RESP_OKAY;
      rdata  <= '0;
    end else begin
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  assign s_axil_rvalid_o = rvalid;
  assign s_axil_rresp_o  = rresp;
  assign s_axil_rdata_o  = rdata;

  // ==========================================================================
  // enable and address registers
  always_comb begin
    next_irq_enable     = irq_enable;
    next_device_address = device_address;
    // only the documented enable bits hold a value
    if (wr_en_sel) begin
      next_irq_enable = (irq_enable & ~(byte_mask & `UIR_EN_WRITABLE))
                      | (w_data & byte_mask & `UIR_EN_WRITABLE);
    end
    // seven address bits, the rest stay zero
    if (wr_addr_sel) begin
      next_device_address = (device_address & ~(byte_mask & `UIR_ADDR_WRITABLE))
                          | (w_data & byte_mask & `UIR_ADDR_WRITABLE);
    end
  end

  // register enables and address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable     <= `UIR_RESET_VALUE;
      device_address <= `UIR_RESET_VALUE;
    end else begin
      irq_enable     <= next_irq_enable;
      device_address <= next_device_address;
    end
  end

  assign device_address_o             = device_address[6:0];
  assign wake_function_enable_o       = irq_enable[`UIR_EN_WAKE_FUNC_BIT];
  assign in_negative_ack_irq_enable_o = irq_enable[`UIR_EN_IN_NAK_BIT];

  // ==========================================================================
  // event flag set and clear vectors
  always_comb begin
    flag_set = '0;
    flag_clr = w1c;
    // an in nak event is dropped while its enable is off
    if (!events_i.ep_is_nak || irq_enable[`UIR_EN_IN_NAK_BIT]) begin
      flag_set[`UIR_EVF_EP_LSB +: 6] = events_i.endpoint;
      flag_set[`UIR_EVF_USB_BIT]     = |events_i.endpoint;
    end
    flag_set[`UIR_EVF_SETUP_BIT] = events_i.setup;
    if (events_i.setup) begin
      flag_set[`UIR_EVF_USB_BIT] = 1'b1;
    end
    flag_set[`UIR_EVF_WAKE_BIT]  = wake_release;
    flag_set[`UIR_EVF_FLOAT_BIT] = events_i.floating;
    flag_set[`UIR_EVF_BUS_BIT]   = events_i.bus;
    // state register reads clear the flags they report
    if (rd_clear_i.sys_state) begin
      flag_clr = flag_clr | `UIR_EVF_TRANS_MASK;
    end
    if (rd_clear_i.bus_state) begin
      flag_clr[`UIR_EVF_BUS_BIT] = 1'b1;
    end
    if (rd_clear_i.float_det) begin
      flag_clr[`UIR_EVF_FLOAT_BIT] = 1'b1;
    end
    // usb flag drops once setup and endpoint flags have all emptied
    if (trans_any_d && !trans_any) begin
      flag_clr[`UIR_EVF_USB_BIT] = 1'b1;
    end
  end

  // sticky flags, set wins over clear
  uir_sticky_flag #(
    .WIDTH (32)
  ) u_flags (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .set_i   (flag_set),
    .clr_i   (flag_clr),
    .flag_o  (irq_event_flags)
  );

  // remember whether transaction flags were held last cycle
  always_comb begin
    trans_any        = |(irq_event_flags & `UIR_EVF_TRANS_MASK);
    next_trans_any_d = trans_any;
  end

  // register the history bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trans_any_d <= 1'b0;
    end else begin
      trans_any_d <= next_trans_any_d;
    end
  end

  // ==========================================================================
  // wakeup hold-off: wait for other usb events to stay absent
  uir_quiet_timer #(
    .CYCLES (WAKE_QUIET_CYCLES)
  ) u_wake_quiet (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (events_i.wake),
    .busy_i  (|(irq_event_flags & ~(32'h1 << `UIR_EVF_WAKE_BIT))),
    .fire_o  (wake_release)
  );

  // ==========================================================================
  // single interrupt line, the controller input must be enabled too
  assign irq_o = |(irq_event_flags[3:0] & irq_enable[3:0]);

endmodule // uir_irq_addr

// ==== core/uir_pkg.sv ====
// types of the usb interrupt enable, event flag and device address block
// assumes event strobes are one-cycle pulses from the serial engine
package uir_pkg;

  // ==========================================================================
  // event strobes from the serial engine, one-cycle pulses
  typedef struct packed {
    logic       setup;       // setup transaction seen
    logic [5:0] endpoint;    // transaction event per endpoint 5..0
    logic       ep_is_nak;   // the endpoint event is an in nak
    logic       wake;        // wakeup from stop seen
    logic       floating;    // floating detect change
    logic       bus;         // bus event (reset, suspend, resume, timeout)
  } uir_events_t;

  // ==========================================================================
  // read strobes of neighbouring state registers, one-cycle pulses
  typedef struct packed {
    logic sys_state;         // system_state_reg was read
    logic bus_state;         // bus_state_reg was read
    logic float_det;         // floating_detect_reg was read
  } uir_rd_clr_t;

endpackage

// ==== core/uir_quiet_timer.sv ====
// holds off an event until a busy level has been low for a number of cycles
// assumes start_i is a one-cycle pulse and busy_i a level
`timescale 1ns/1ps

module uir_quiet_timer #(
  parameter int unsigned CYCLES = 4000000
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic busy_i,
  output logic      fire_o
);

  localparam int CW = $clog2(CYCLES + 1);

  // ==========================================================================
  // state
  logic          armed;       // a wakeup is waiting
  logic          next_armed;
  logic [CW-1:0] count;       // quiet cycles seen so far
  logic [CW-1:0] next_count;
  logic          fire;        // one-cycle release pulse
  logic          next_fire;

  // count quiet cycles; any busy cycle starts the wait again
  always_comb begin
    next_armed = armed;
    next_count = count;
    next_fire  = 1'b0;
    if (start_i) begin
      next_armed = 1'b1;
      next_count = '0;
    end else if (armed) begin
      if (busy_i) begin
        next_count = '0;
      end else if (count >= CW'(CYCLES)) begin
        next_fire  = 1'b1;
        next_armed = 1'b0;
        next_count = '0;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  // register the timer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed <= 1'b0;
      count <= '0;
      fire  <= 1'b0;
    end else begin
      armed <= next_armed;
      count <= next_count;
      fire  <= next_fire;
    end
  end

  assign fire_o = fire;

endmodule // uir_quiet_timer

// ==== core/uir_sticky_flag.sv ====
// vector of sticky flags, set by hardware and cleared by a clear vector
// assumes set and clear are synchronous to clk_i
`timescale 1ns/1ps

module uir_sticky_flag #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] flag_o
);

  // ==========================================================================
  // state
  logic [WIDTH-1:0] flag;       // held flags
  logic [WIDTH-1:0] next_flag;  // next flags

  // set wins over clear in the same cycle so no event is lost
  always_comb begin
    next_flag = (flag & ~clr_i) | set_i;
  end

  // register the flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule // uir_sticky_flag

// ==== verification/uir_host_model.sv ====
// far-side model: turns bench requests into one-cycle engine strobes
// assumes fire_i is high for exactly one clk_i cycle
`timescale 1ns/1ps

module uir_host_model (
  input  wire logic                 clk_i,
  input  wire logic                 fire_i,
  input  wire logic [3:0]           delay_i,
  input  wire uir_pkg::uir_events_t ev_i,
  input  wire uir_pkg::uir_rd_clr_t clr_i,
  output uir_pkg::uir_events_t      events_o,
  output uir_pkg::uir_rd_clr_t      rd_clear_o
);
  import uir_pkg::*;
  // ==========================================================================
  // strobes last one cycle, sent at once or after delay_i cycles
  initial begin
    events_o = '0;
    rd_clear_o = '0;
    forever begin
      @(posedge clk_i);
      if (fire_i) begin
        repeat (delay_i) @(posedge clk_i);
        events_o <= ev_i;
        rd_clear_o <= clr_i;
        @(posedge clk_i);
        events_o <= '0;
        rd_clear_o <= '0;
      end
    end
  end
endmodule // uir_host_model

// ==== verification/uir_irq_addr_props.sv ====
// checker of uir_irq_addr: bus handshakes, enable outputs, interrupt line
// assumes one clock domain and the top module's port names
`timescale 1ns/1ps

module uir_irq_addr_props (
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 s_axil_awready_o,
  input wire logic                 s_axil_wready_o,
  input wire logic                 s_axil_bvalid_o,
  input wire logic                 s_axil_arvalid_i,
  input wire logic                 s_axil_arready_o,
  input wire logic                 s_axil_rvalid_o,
  input wire logic                 s_axil_rready_i,
  input wire uir_pkg::uir_rd_clr_t rd_clear_i,
  input wire logic [6:0]           device_address_o,
  input wire logic                 wake_function_enable_o,
  input wire logic                 in_negative_ack_irq_enable_o,
  input wire logic                 irq_o
);
  import uir_pkg::*;
  // ==========================================================================
  // checks on clk_i, silent while reset is held
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // a pending response blocks both write halves
  write_refuse_a: assert property (s_axil_bvalid_o |-> !s_axil_awready_o && !s_axil_wready_o)
    else $error("write taken while a response waits");
  read_refuse_a: assert property (s_axil_rvalid_o |-> !s_axil_arready_o)
    else $error("read taken while data waits");
  read_answer_a: assert property (s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o)
    else $error("read data late");
  read_once_a: assert property (s_axil_rvalid_o && s_axil_rready_i |=> !s_axil_rvalid_o)
    else $error("read data repeated");
  // enable and address outputs only move with a completed write
  nak_enable_a: assert property ($changed(in_negative_ack_irq_enable_o) |-> $rose(s_axil_bvalid_o))
    else $error("nak enable moved without a write");
  wake_func_a: assert property ($changed(wake_function_enable_o) |-> $rose(s_axil_bvalid_o))
    else $error("wake function moved without a write");
  addr_write_a: assert property ($changed(device_address_o) |-> $rose(s_axil_bvalid_o))
    else $error("address moved without a write");
  // the interrupt drops only after a write, a read clear or the usb auto clear
  irq_drop_a: assert property ($fell(irq_o) |-> s_axil_bvalid_o || $past(s_axil_bvalid_o)
    || $past(|rd_clear_i) || $past(rd_clear_i.sys_state, 2))
    else $error("interrupt dropped without a cause");
endmodule // uir_irq_addr_props

bind uir_irq_addr uir_irq_addr_props u_props (
  .clk_i, .rst_n_i, .s_axil_awready_o, .s_axil_wready_o, .s_axil_bvalid_o, .s_axil_arvalid_i,
  .s_axil_arready_o, .s_axil_rvalid_o, .s_axil_rready_i, .rd_clear_i, .device_address_o,
  .wake_function_enable_o, .in_negative_ack_irq_enable_o, .irq_o);

// ==== verification/uir_irq_addr_tb.sv ====
// self-checking bench of uir_irq_addr against an integer register model
// assumes the host model strobes events and one bus access is in flight
`timescale 1ns/1ps

module uir_irq_addr_tb;
  import uir_pkg::*;
  // ==========================================================================
  // stimulus, dut wires and reference model
  localparam int unsigned QUIET = 20;            // shortened wake quiet time
  localparam logic [31:0] TM = 32'h803F_0000;    // setup and endpoint flags
  localparam int EPOS [9] = '{0, 1, 4, 5, 6, 7, 8, 9, 10};
  localparam int FPOS [9] = '{0, 2, 16, 17, 18, 19, 20, 21, 31};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] awa = '0, ara = '0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, fire = 1'b0;
  logic [31:0] wd = '0, got, r, m_en = '0, m_flg = '0;
  logic [3:0] dly = '0;
  logic [1:0] gr;
  wire logic awr, wrd, bv, arr, rv, wfe, nke, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  wire logic [6:0] dadr;
  uir_events_t ev_req = '0, ev, e;
  uir_rd_clr_t clr_req = '0, clr, c;
  int fail_count = 0, samples_checked = 0;

  always #2.5 clk_i = ~clk_i;

  uir_irq_addr #(.ADDR_W(12), .WAKE_QUIET_CYCLES(QUIET)) dut (
    .clk_i, .rst_n_i, .s_axil_awaddr_i(awa), .s_axil_awvalid_i(awv), .s_axil_awready_o(awr),
    .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'hF), .s_axil_wvalid_i(wv), .s_axil_wready_o(wrd),
    .s_axil_bresp_o(br), .s_axil_bvalid_o(bv), .s_axil_bready_i(bre), .s_axil_araddr_i(ara),
    .s_axil_arvalid_i(arv), .s_axil_arready_o(arr), .s_axil_rdata_o(rd), .s_axil_rresp_o(rr),
    .s_axil_rvalid_o(rv), .s_axil_rready_i(rre), .events_i(ev), .rd_clear_i(clr),
    .device_address_o(dadr), .wake_function_enable_o(wfe), .in_negative_ack_irq_enable_o(nke),
    .irq_o(irq));
  uir_host_model host (.clk_i, .fire_i(fire), .delay_i(dly), .ev_i(ev_req), .clr_i(clr_req),
    .events_o(ev), .rd_clear_o(clr));

  // ==========================================================================
  // compares, bus tasks and model updates
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("Error %0t: word %h, expected %h", $time, g, x);
    end
  endtask

  task automatic chk_pin(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("Error %0t: pin %b, expected %b", $time, g, x);
    end
  endtask

  // write: both halves offered together, each dropped when taken
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] xr);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_i);
      ta = pa && awr;
      tw = pw && wrd;
      @(posedge clk_i);
      if (ta) begin
        awv <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wv <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge clk_i); while (bv !== 1'b1);
    gr = br;
    @(posedge clk_i);
    bre <= 1'b0;
    chk_word({30'h0, gr}, {30'h0, xr});
  endtask

  // read: address held until taken, data taken with rvalid
  task automatic bus_rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr);
    logic t;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge clk_i);
      t = arr;
      @(posedge clk_i);
    end while (t !== 1'b1);
    arv <= 1'b0;
    do @(negedge clk_i); while (rv !== 1'b1);
    got = rd;
    gr = rr;
    @(posedge clk_i);
    rre <= 1'b0;
    chk_word(got, x);
    chk_word({30'h0, gr}, {30'h0, xr});
  endtask

  // ask the host model for one strobe and let it land
  task automatic strobe(input uir_events_t se, input uir_rd_clr_t sc, input logic [3:0] d);
    @(posedge clk_i);
    ev_req <= se;
    clr_req <= sc;
    dly <= d;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (int'(d) + 3) @(posedge clk_i);
  endtask

  // usb flag falls when setup and endpoint flags all go to zero
  task automatic m_clr(input logic [31:0] cm);
    logic o;
    o = |(m_flg & TM);
    m_flg &= ~cm;
    if (o && !(|(m_flg & TM))) m_flg[1] = 1'b0;
  endtask

  task automatic irq_chk;
    @(negedge clk_i);
    chk_pin(irq, |(m_flg[3:0] & m_en[3:0]));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // watchdog, well past the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict;
  end

  // ==========================================================================
  // main sequence
  initial begin
    r = $urandom(65);
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 3; i++) bus_rd(12'(4 * i), 32'h0, 2'h0);
    bus_wr(12'h00C, $urandom, 2'h2);
    bus_rd(12'h00C, 32'h0, 2'h2);
    repeat (2) begin
      r = $urandom;
      bus_wr(12'h008, r, 2'h0);
      bus_rd(12'h008, r & 32'h7F, 2'h0);
      chk_word({25'h0, dadr}, r & 32'h7F);
    end
    // each source but wake: set, check, then clear by write-one or by a state read
    for (int k = 0; k < 9; k++) begin
      r = $urandom;
      bus_wr(12'h000, r, 2'h0);
      m_en = r & 32'h0000_810F;
      bus_rd(12'h000, m_en & 32'h0000_010F, 2'h0);
      chk_pin(wfe, m_en[8]);
      chk_pin(nke, m_en[15]);
      e = uir_events_t'(11'h1 << EPOS[k]);
      c = (k == 0) ? 3'h2 : (k == 1) ? 3'h1 : 3'h4;
      strobe(e, '0, 4'($urandom_range(3, 0)));
      m_flg[FPOS[k]] = 1'b1;
      if (k > 1) m_flg[1] = 1'b1;
      bus_rd(12'h004, m_flg, 2'h0);
      irq_chk;
      if (k % 2 == 1) bus_wr(12'h004, 32'h1 << FPOS[k], 2'h0);
      else strobe('0, c, 4'h0);
      m_clr(32'h1 << FPOS[k]);
      bus_rd(12'h004, m_flg, 2'h0);
      irq_chk;
    end
    // usb flag cleared alone while an endpoint flag stays
    strobe(uir_events_t'(11'h010), '0, 4'h0);
    bus_wr(12'h004, 32'h2, 2'h0);
    bus_rd(12'h004, 32'h0001_0000, 2'h0);
    strobe('0, 3'h4, 4'h0);
    bus_rd(12'h004, 32'h0, 2'h0);
    // in nak events need their enable
    bus_wr(12'h000, 32'h0000_0002, 2'h0);
    strobe(uir_events_t'(11'h088), '0, 4'h1);
    bus_rd(12'h004, 32'h0, 2'h0);
    bus_wr(12'h000, 32'h0000_8002, 2'h0);
    strobe(uir_events_t'(11'h088), '0, 4'h1);
    bus_rd(12'h004, 32'h0008_0002, 2'h0);
    strobe('0, 3'h4, 4'h0);
    bus_rd(12'h004, 32'h0, 2'h0);
    // wake flag waits for quiet, survives reads, clears by write-one
    m_en = 32'h0000_0008;
    bus_wr(12'h000, m_en, 2'h0);
    strobe(uir_events_t'(11'h004), '0, 4'h0);
    m_flg = '0;
    bus_rd(12'h004, m_flg, 2'h0);
    irq_chk;
    repeat (QUIET + 8) @(posedge clk_i);
    m_flg = 32'h8;
    strobe('0, 3'h7, 4'h0);
    bus_rd(12'h004, m_flg, 2'h0);
    irq_chk;
    bus_wr(12'h004, 32'h8, 2'h0);
    m_flg = '0;
    bus_rd(12'h004, m_flg, 2'h0);
    irq_chk;
    give_verdict;
  end
endmodule // uir_irq_addr_tb
